// *** verilog/rcp_collision_status.sv ***
// Collision position status for the contactless receive path, with APB access.
// Assumes the bit decoder is on i_clk and marks frame start, data bits and
// collisions with one-cycle strobes; no synchronisers are therefore needed.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps

// Notes on behaviour
// R1: Keep-bits zero clears bits after collision.
// R2: Host keeps keep-bits one except anticollision.
// R3: Invalid flag when none or out of range.
// R4: Field holds first collision position, data bits.
// R5: 01h first bit, 00h thirty-second bit.
// R6: Host reads position only when flag clear.
// R7: Host reads flag only in 106k/type A.
// R8: Reset keep one, bit6 zero, invalid one.
// R9: New frame reinitialises; only first collision latched.
module rcp_collision_status
   import rcp_pkg::*;
#(
   parameter int MAX_POS = 32
) (
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   // APB slave
   input  wire logic          i_psel,
   input  wire logic          i_penable,
   input  wire logic          i_pwrite,
   input  wire logic [7:0]    i_paddr,
   input  wire logic [31:0]   i_pwdata,
   output logic      [31:0]   o_prdata,
   output logic               o_pready,
   output logic               o_pslverr,
   // Receive path
   input  wire rcp_rx_type    i_rx,
   output rcp_store_type      o_store,
   // Interrupt
   output logic               o_irq
);

   // -----------------------------------------------------------------------
   // Types and signals
   // -----------------------------------------------------------------------

   // Receive framing state; data bits are only counted inside a frame.
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b01,
      RX_FRAME = 2'b10
   } rcp_rx_state_type;

   // Receive framing state.
   rcp_rx_state_type         rx_state_reg;
   rcp_rx_state_type         rx_state_next;

   // Collision status fields.
   logic                     keep_bits_after_collision_reg;
   logic                     collision_position_invalid_reg;
   logic [RCP_POS_WIDTH-1:0] first_collision_position_reg;
   logic                     collided_reg;

   // Data bit counter.
   logic [5:0]               bit_count_reg;
   logic [5:0]               bit_count_next;
   logic                     bit_count_full;
   logic                     in_range;

   // Receive strobes qualified by the framing state.
   logic                     rx_bit;
   logic                     first_coll;

   // Interrupt bookkeeping.
   logic [RCP_IRQ_WIDTH-1:0] irq_status_reg;
   logic [RCP_IRQ_WIDTH-1:0] irq_mask_reg;
   logic [RCP_IRQ_WIDTH-1:0] irq_event;
   logic [RCP_IRQ_WIDTH-1:0] irq_clear;

   // APB decode and read path.
   logic                     sel_coll;
   logic                     sel_irq_status;
   logic                     sel_irq_mask;
   logic                     addr_ok;
   logic                     wr_acc;
   logic                     rd_setup;
   logic [31:0]              rdata_next;

   // -----------------------------------------------------------------------
   // Receive framing
   // -----------------------------------------------------------------------

   always_comb begin
      rx_state_next = rx_state_reg;
      case (rx_state_reg)
         RX_IDLE: begin
            if (i_rx.frame_start) begin
               rx_state_next = RX_FRAME;
            end
         end
         RX_FRAME: begin
            if (i_rx.frame_end && !i_rx.frame_start) begin
               rx_state_next = RX_IDLE;
            end
         end
         default: begin
            rx_state_next = RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_state_reg <= RX_IDLE;
      end else begin
         rx_state_reg <= rx_state_next;
      end
   end

   // -----------------------------------------------------------------------
   // Bit counter
   // -----------------------------------------------------------------------

   assign rx_bit         = i_rx.bit_valid && !i_rx.frame_start && (rx_state_reg == RX_FRAME);
   assign bit_count_full = (bit_count_reg == 6'h3f);
   assign bit_count_next = bit_count_reg + 6'h01;
   // The compare uses the count before the increment, so a saturated count cannot wrap in.
   assign in_range       = (int'(bit_count_reg) < MAX_POS);
   assign first_coll     = rx_bit && i_rx.bit_collision && !collided_reg;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         bit_count_reg <= 6'h00;
      end else if (i_rx.frame_start) begin
         bit_count_reg <= 6'h00;                                   // [R9]
      end else if (rx_bit && !bit_count_full) begin
         bit_count_reg <= bit_count_next;                          // [R4]
      end
   end

   // -----------------------------------------------------------------------
   // Collision capture
   // -----------------------------------------------------------------------

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         collided_reg                   <= 1'b0;
         collision_position_invalid_reg <= RCP_INVALID_RESET;      // [R8]
         first_collision_position_reg   <= RCP_POS_RESET;
      end else if (i_rx.frame_start) begin
         collided_reg                   <= 1'b0;                   // [R9]
         collision_position_invalid_reg <= 1'b1;                   // [R3]
         first_collision_position_reg   <= RCP_POS_RESET;
      end else if (first_coll) begin
         collided_reg <= 1'b1;                                     // [R9]
         if (in_range) begin
            collision_position_invalid_reg <= 1'b0;
            // Bit 32 wraps to 00h in the five-bit field.
            first_collision_position_reg   <= bit_count_next[4:0]; // [R5]
         end else begin
            collision_position_invalid_reg <= 1'b1;                // [R3]
         end
      end
   end

   // -----------------------------------------------------------------------
   // Stored bit stream
   // -----------------------------------------------------------------------

   // Bits after the first collision are stored as zero unless kept.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_store <= '0;
      end else begin
         o_store.bit_valid <= i_rx.bit_valid;
         o_store.bit_data  <= i_rx.bit_data &&
                              (keep_bits_after_collision_reg || !collided_reg); // [R1]
      end
   end

   // -----------------------------------------------------------------------
   // Interrupt events
   // -----------------------------------------------------------------------

   always_comb begin
      irq_event = '0;
      irq_event[RCP_IRQ_COLL_BIT]  = first_coll;
      irq_event[RCP_IRQ_FRAME_BIT] = i_rx.frame_end;
   end

   always_comb begin
      irq_clear = '0;
      if (wr_acc && sel_irq_status) begin
         irq_clear = i_pwdata[RCP_IRQ_WIDTH-1:0];
      end
   end

   // -----------------------------------------------------------------------
   // Interrupt status
   // -----------------------------------------------------------------------

   // A new event wins over a write-one-to-clear in the same cycle.
   generate
      for (genvar g = 0; g < RCP_IRQ_WIDTH; g++) begin : g_irq
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               irq_status_reg[g] <= RCP_IRQ_RESET[g];
            end else if (irq_event[g]) begin
               irq_status_reg[g] <= 1'b1;
            end else if (irq_clear[g]) begin
               irq_status_reg[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // The interrupt line follows the masked status one cycle later.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // -----------------------------------------------------------------------
   // APB decode
   // -----------------------------------------------------------------------

   assign sel_coll       = (i_paddr == RCP_COLL_STATUS_OFFS);
   assign sel_irq_status = (i_paddr == RCP_IRQ_STATUS_OFFS);
   assign sel_irq_mask   = (i_paddr == RCP_IRQ_MASK_OFFS);
   assign addr_ok        = sel_coll || sel_irq_status || sel_irq_mask;
   // A setup cycle is answered in the following access cycle.
   assign wr_acc         = i_psel && i_penable && i_pwrite && o_pready;
   assign rd_setup       = i_psel && !i_penable;

   // -----------------------------------------------------------------------
   // Writable controls
   // -----------------------------------------------------------------------

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         keep_bits_after_collision_reg <= RCP_KEEP_RESET;          // [R8]
      end else if (wr_acc && sel_coll) begin
         keep_bits_after_collision_reg <= i_pwdata[RCP_KEEP_BIT];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_mask_reg <= RCP_IRQ_RESET;
      end else if (wr_acc && sel_irq_mask) begin
         irq_mask_reg <= i_pwdata[RCP_IRQ_WIDTH-1:0];
      end
   end

   // -----------------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------------

   // Reserved bits, bit 6 included, read as zero.
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (sel_coll) begin
         rdata_next[RCP_KEEP_BIT]    = keep_bits_after_collision_reg;
         rdata_next[RCP_INVALID_BIT] = collision_position_invalid_reg;
         rdata_next[RCP_POS_MSB:0]   = first_collision_position_reg;
      end else if (sel_irq_status) begin
         rdata_next[RCP_IRQ_WIDTH-1:0] = irq_status_reg;
      end else if (sel_irq_mask) begin
         rdata_next[RCP_IRQ_WIDTH-1:0] = irq_mask_reg;
      end
   end

   // -----------------------------------------------------------------------
   // Read response
   // -----------------------------------------------------------------------

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= rd_setup;
         o_pslverr <= rd_setup && !addr_ok;
         if (rd_setup && !i_pwrite) begin
            o_prdata <= rdata_next;
         end
      end
   end

endmodule

// *** verilog/rcp_pkg.sv ***
// Package for the collision position status block: register map, field layout,
// reset values and the structs that carry the receive-path input and the stored output.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package rcp_pkg;

   // -----------------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------------
   // The collision status register sits at word index 0Eh, so its byte address is four times that.
   localparam logic [7:0] RCP_COLL_STATUS_INDEX = 8'h0e;
   localparam logic [7:0] RCP_COLL_STATUS_OFFS  = 8'(RCP_COLL_STATUS_INDEX * 4);
   localparam logic [7:0] RCP_IRQ_STATUS_OFFS  = 8'h20;
   localparam logic [7:0] RCP_IRQ_MASK_OFFS    = 8'h24;

   // -----------------------------------------------------------------------
   // Field positions of the collision status register
   // -----------------------------------------------------------------------
   localparam int RCP_KEEP_BIT    = 7;
   localparam int RCP_INVALID_BIT = 5;
   localparam int RCP_POS_MSB     = 4;
   localparam int RCP_POS_WIDTH   = 5;

   // -----------------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------------
   localparam logic       RCP_KEEP_RESET    = 1'b1;
   localparam logic       RCP_INVALID_RESET = 1'b1;
   localparam logic [4:0] RCP_POS_RESET     = 5'h00;
   localparam logic [1:0] RCP_IRQ_RESET     = 2'h0;

   // -----------------------------------------------------------------------
   // Interrupt event bits
   // -----------------------------------------------------------------------
   localparam int RCP_IRQ_COLL_BIT  = 0;
   localparam int RCP_IRQ_FRAME_BIT = 1;
   localparam int RCP_IRQ_WIDTH     = 2;

   // Receive-path bit stream from the decoder.
   typedef struct packed {
      logic frame_start;
      logic frame_end;
      logic bit_valid;
      logic bit_data;
      logic bit_collision;
   } rcp_rx_type;

   // Bit stream handed on toward the receive buffer.
   typedef struct packed {
      logic bit_valid;
      logic bit_data;
   } rcp_store_type;

endpackage

// *** testbench/rcp_collision_props.sv ***
// Assertions on the collision status block ports.
// Assumes binding to rcp_collision_status on its single clock.
`timescale 1ns/1ps
module rcp_collision_props
   import rcp_pkg::*;
(
   // Watched ports
   input wire logic          i_clk,
   input wire logic          i_rst,
   input wire logic          i_psel,
   input wire logic          i_penable,
   input wire logic          i_pwrite,
   input wire logic [7:0]    i_paddr,
   input wire logic [31:0]   i_pwdata,
   input wire logic [31:0]   o_prdata,
   input wire logic          o_pready,
   input wire rcp_rx_type    i_rx,
   input wire rcp_store_type o_store
);
   logic       cs_reg;
   logic       keep_reg;
   logic [5:0] cnt_reg;
   logic [5:0] pos_reg;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Tracks the frame's first collision and the keep control.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         {cs_reg, keep_reg, cnt_reg, pos_reg} <= 14'h1000;
      end else begin
         if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == RCP_COLL_STATUS_OFFS)
            keep_reg <= i_pwdata[7];
         if (i_rx.frame_start) begin
            {cs_reg, cnt_reg} <= 7'h00;
         end else if (i_rx.bit_valid) begin
            cnt_reg <= cnt_reg + 6'h01;
            if (i_rx.bit_collision && !cs_reg) begin
               {cs_reg, pos_reg} <= {1'b1, cnt_reg + 6'h01};
            end
         end
      end
   end
   sequence s_rd;
      i_psel && !i_penable && !i_pwrite && i_paddr == RCP_COLL_STATUS_OFFS;
   endsequence
   a_invalid_flag: assert property (s_rd |=> o_prdata[5] == (!cs_reg || pos_reg > 6'h20))
      else $error("invalid flag wrong");
   a_first_pos: assert property (s_rd ##0 cs_reg && pos_reg <= 6'h20
      |=> o_prdata[4:0] == pos_reg[4:0]) else $error("position wrong");
   a_reg_layout: assert property (s_rd |=> o_prdata[31:6] == {24'h0, keep_reg, 1'b0})
      else $error("status layout wrong");
   a_store_valid: assert property (i_rx.bit_valid |=> o_store.bit_valid)
      else $error("stored bit missing");
   a_store_pass: assert property (i_rx.bit_valid && !cs_reg
      |=> o_store.bit_data == $past(i_rx.bit_data)) else $error("bit altered");
   a_bits_cleared: assert property (i_rx.bit_valid && cs_reg && !keep_reg
      |=> !o_store.bit_data) else $error("bit not cleared");
endmodule
bind rcp_collision_status rcp_collision_props u_props (.i_clk, .i_rst, .i_psel, .i_penable,
   .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .i_rx, .o_store);

// *** testbench/rcp_card_model.sv ***
// Card-side model: sends framed bit streams with chosen collisions.
// Assumes the block's clock; drives the receive stream only.
`timescale 1ns/1ps
module rcp_card_model
   import rcp_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Receive stream
   output rcp_rx_type o_rx
);
   logic st, en, v, d, c, tg;
   initial {st, en, v, d, c, tg} = 6'h00;
   // Between bits the data line toggles rather than holding its last value.
   always @(posedge i_clk) tg <= ~tg;
   assign o_rx = {st, en, v, v ? d : tg, c};
   task automatic send(input int n, c1, c2, input logic [63:0] dat, input logic slow);
      st <= 1'b1;
      for (int i = 1; i <= n; i++) begin
         @(posedge i_clk);
         {st, v, d, c} <= {2'b01, dat[i-1], 1'(i == c1 || i == c2)};
         if (slow) begin
            @(posedge i_clk);
            v <= 1'b0;
         end
      end
      @(posedge i_clk);
      {st, v, c, en} <= 4'b0001;
      @(posedge i_clk);
      en <= 1'b0;
   endtask
endmodule

// *** testbench/rcp_collision_status_tb_top.sv ***
// Self-checking bench for the collision status block over APB.
// Assumes the card model drives the receive stream on the same clock.
`timescale 1ns/1ps
module rcp_collision_status_tb_top
   import rcp_pkg::*;
;
   logic          i_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq;
   logic [7:0]    i_paddr;
   logic [31:0]   i_pwdata, o_prdata;
   rcp_rx_type    i_rx;
   logic [32:0]   q[$];
   int            errors, check_count, seed, n;
   rcp_collision_status dut (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rx, .o_store(), .o_irq);
   rcp_card_model card (.i_clk, .o_rx(i_rx));
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task automatic cmp(input string nm, input logic [32:0] e, s);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   always @(posedge i_clk) if (o_pready === 1'b1 && !i_pwrite) cmp("read", q.pop_front(), {o_pslverr, o_prdata});
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int k;
      k = 0;
      {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, wd};
      @(posedge i_clk);
      i_penable <= 1'b1;
      do @(posedge i_clk); while (o_pready !== 1'b1 && k++ < 50);
      if (k >= 50) begin
         errors++;
         summarize();
      end
      {i_psel, i_penable} <= 2'b00;
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      q.push_back(e);
      apb(a, 1'b0, 32'h0);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge i_clk);
      errors++;
      summarize();
   end
   initial begin
      seed = 70018;
      {i_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 43'h0};
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(RCP_COLL_STATUS_OFFS, 33'h0a0);
      apb(RCP_COLL_STATUS_OFFS, 1'b1, 32'h7f);
      rd(RCP_COLL_STATUS_OFFS, 33'h020);
      rd(8'h30, 33'h100000000);
      apb(RCP_IRQ_MASK_OFFS, 1'b1, 32'h1);
      for (int t = 0; t < 8; t++) begin
         n = (t < 4) ? ((t == 0) ? 1 : (t == 1) ? 8 : 32 + (t == 3)) : {$random(seed)} % 30 + 2;
         if (t == 4) apb(RCP_COLL_STATUS_OFFS, 1'b1, 32'h80);
         card.send(34, n, n + 1, {$random(seed), $random(seed)}, t[0]);
         repeat (3) @(posedge i_clk);
         rd(RCP_COLL_STATUS_OFFS, {25'h0, 1'(t >= 4), 1'b0, 1'(n > 32), n > 32 ? 5'h0 : 5'(n)});
      end
      cmp("irq", 33'h1, {32'h0, o_irq});
      rd(RCP_IRQ_STATUS_OFFS, 33'h3);
      apb(RCP_IRQ_STATUS_OFFS, 1'b1, 32'h1);
      @(posedge i_clk);
      cmp("irq", 33'h0, {32'h0, o_irq});
      rd(RCP_IRQ_STATUS_OFFS, 33'h2);
      card.send(10, 0, 0, {$random(seed), $random(seed)}, 1'b0);
      repeat (3) @(posedge i_clk);
      rd(RCP_COLL_STATUS_OFFS, 33'h0a0);
      summarize();
   end
endmodule
